// ### logic/dtc_pkg.sv
// package for the dual timer/counter block: register layout, modes, carriers
package dtc_pkg;
  // special function register addresses
  localparam logic [7:0] TCS_ADDR = 8'h88;
  localparam logic [7:0] TMODE_ADDR = 8'h89;
  localparam logic [7:0] T0L_ADDR = 8'h8a;
  localparam logic [7:0] T1L_ADDR = 8'h8b;
  localparam logic [7:0] T0H_ADDR = 8'h8c;
  localparam logic [7:0] T1H_ADDR = 8'h8d;
  localparam logic [7:0] TCS_RESET = 8'h00;
  localparam logic [7:0] TMODE_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hff;
  localparam logic [4:0] M0_LOW_ONES = 5'h1f;
  // timer_control_status bit positions
  localparam int TCS_TF1 = 7;
  localparam int TCS_TR1 = 6;
  localparam int TCS_TF0 = 5;
  localparam int TCS_TR0 = 4;
  localparam int TCS_IE1 = 3;
  localparam int TCS_IT1 = 2;
  localparam int TCS_IE0 = 1;
  localparam int TCS_IT0 = 0;
  // timer_mode_register field positions, per-timer nibble
  localparam int TMODE_NIB = 4;
  localparam int NIB_GATE = 3;
  localparam int NIB_CSEL = 2;
  localparam int NIB_MODE_HI = 1;
  localparam int NIB_MODE_LO = 0;

  typedef enum logic [1:0] {
    DTC_MODE_13 = 2'h0,
    DTC_MODE_16 = 2'h1,
    DTC_MODE_RELOAD = 2'h2,
    DTC_MODE_SPLIT = 2'h3
  } dtc_mode_t;

  // processor special function register access
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dtc_sfr_req_t;

  // interrupt vectoring acknowledges and external pins
  typedef struct packed {
    logic t0_ack;
    logic t1_ack;
    logic x0_ack;
    logic x1_ack;
  } dtc_ack_t;

  typedef struct packed {
    logic [2:0] cnt0;
    logic [2:0] cnt1;
    logic [2:0] irq0;
    logic [2:0] irq1;
  } dtc_sync_t;

  typedef struct packed {
    dtc_sync_t sync;
    logic [7:0] tcs;
    logic [7:0] tmode;
    logic [7:0] t0_low;
    logic [7:0] t0_high;
    logic [7:0] t1_low;
    logic [7:0] t1_high;
    logic [7:0] rdata;
    logic t0_irq;
    logic t1_irq;
    logic x0_irq;
    logic x1_irq;
    logic t1_ovf;
  } dtc_state_t;
endpackage

// ### logic/dtc_top.sv
// dual timer/counter with shared control/status register
//
// Notes on behaviour
// - mode 1 counts the low and high bytes as one 16-bit register
// - mode 2 counts in the low byte, the high byte holds reload value
// - mode 2 rollover sets overflow flag and copies high byte into low
// - reload leaves the high byte untouched
// - a set overflow flag raises that timer's enabled interrupt request
// - timer 0 and, outside split mode, timer 1 count only with run set and gate clear or external input active
// - mode 3 low byte is an 8-bit counter using timer 0 controls
// - mode 3 low byte takes the internal timebase or external count input
// - mode 3 high byte counts only the internal timebase
// - mode 3 high byte runs only while timer 1 run bit is set
// - mode 3 high byte overflow sets timer 1 overflow flag
// - timer 1 under split mode ignores external clocking, never sets its flag
// - timer 1 overflow pulse stays available under split mode
// - under split mode timer 1 runs in modes 0-2, stops in mode 3
// - setting run never clears the count registers
// - count select one increments on falling edges of the count pin
`timescale 1ns/1ps
`default_nettype none

module dtc_top (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire dtc_pkg::dtc_sfr_req_t i_sfr,
  input wire dtc_pkg::dtc_ack_t i_ack,
  input wire logic i_timer0_irq_enable,
  input wire logic i_timer1_irq_enable,
  input wire logic i_ext_irq0_polarity,
  input wire logic i_ext_irq1_polarity,
  input wire logic i_timer0_sysclk_select,
  input wire logic i_timer1_sysclk_select,
  input wire logic i_prescale_tick,
  input wire logic i_timer0_count_pin,
  input wire logic i_timer1_count_pin,
  input wire logic i_ext_irq0_input,
  input wire logic i_ext_irq1_input,
  output logic [7:0] o_sfr_rdata,
  output logic o_timer0_irq,
  output logic o_timer1_irq,
  output logic o_ext_irq0_req,
  output logic o_ext_irq1_req,
  output logic o_timer1_overflow
);

  dtc_pkg::dtc_state_t s_q;
  dtc_pkg::dtc_state_t s_d;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [3:0] nib(input logic [7:0] tm, input int t);
    nib = tm[t*dtc_pkg::TMODE_NIB +: dtc_pkg::TMODE_NIB];
  endfunction

  // a falling edge is seen while stage three is still high and stage two has gone low
  function automatic logic fell(input logic [2:0] sh);
    fell = (sh[2] == 1'b1) && (sh[1] == 1'b0);
  endfunction

  // the level of a synchronised pin, taken from stage three
  function automatic logic lvl(input logic [2:0] sh);
    lvl = sh[2];
  endfunction

  // ------------------------------------------------------------
  // decoded controls and per-cycle events
  // ------------------------------------------------------------
  logic [3:0] n0;
  logic [3:0] n1;
  dtc_pkg::dtc_mode_t m0;
  dtc_pkg::dtc_mode_t m1;
  logic split;
  logic x0_act;
  logic x1_act;
  logic x0_act_next;
  logic x1_act_next;
  logic en0;
  logic en1;
  logic tick0;
  logic tick1;
  logic int_tick0;
  logic int_tick1;
  logic [15:0] c16;
  logic [8:0] c9;
  logic ovf0;
  logic ovf1;
  logic ovf_th0;
  logic wr_tcs;

  always_comb begin
    n0 = nib(s_q.tmode, 0);
    n1 = nib(s_q.tmode, 1);
    m0 = dtc_pkg::dtc_mode_t'(n0[dtc_pkg::NIB_MODE_HI:dtc_pkg::NIB_MODE_LO]);
    m1 = dtc_pkg::dtc_mode_t'(n1[dtc_pkg::NIB_MODE_HI:dtc_pkg::NIB_MODE_LO]);
    split = (m0 == dtc_pkg::DTC_MODE_SPLIT);
    x0_act = (lvl(s_q.sync.irq0) == i_ext_irq0_polarity);
    x1_act = (lvl(s_q.sync.irq1) == i_ext_irq1_polarity);
    // the level that stage three takes at the next edge; comparing it with the
    // present level finds an edge without a fourth flop per pin
    x0_act_next = (s_q.sync.irq0[1] == i_ext_irq0_polarity);
    x1_act_next = (s_q.sync.irq1[1] == i_ext_irq1_polarity);
    en0 = s_q.tcs[dtc_pkg::TCS_TR0] && (!n0[dtc_pkg::NIB_GATE] || x0_act);
    en1 = s_q.tcs[dtc_pkg::TCS_TR1] && (!n1[dtc_pkg::NIB_GATE] || x1_act);
    // sysclk select makes every cycle a tick, else the prescaler pulse counts
    int_tick0 = i_timer0_sysclk_select || i_prescale_tick;
    int_tick1 = i_timer1_sysclk_select || i_prescale_tick;
    tick0 = n0[dtc_pkg::NIB_CSEL] ? fell(s_q.sync.cnt0) : int_tick0;
    // timer 1 ignores its count pin while timer 0 is split
    tick1 = (n1[dtc_pkg::NIB_CSEL] && !split) ? fell(s_q.sync.cnt1) : int_tick1;
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    ovf0 = 1'b0;
    ovf1 = 1'b0;
    ovf_th0 = 1'b0;
    c16 = 16'h0000;
    c9 = 9'h000;
    wr_tcs = i_sfr.wr && (i_sfr.addr == dtc_pkg::TCS_ADDR);
    // three-stage synchronisers
    // only the shift reads stage one; edges and levels use stages two and three
    s_d.sync.cnt0 = {s_q.sync.cnt0[1:0], i_timer0_count_pin};
    s_d.sync.cnt1 = {s_q.sync.cnt1[1:0], i_timer1_count_pin};
    s_d.sync.irq0 = {s_q.sync.irq0[1:0], i_ext_irq0_input};
    s_d.sync.irq1 = {s_q.sync.irq1[1:0], i_ext_irq1_input};

    // software writes first; hardware events below override clears
    if (i_sfr.wr) begin
      unique case (i_sfr.addr)
        dtc_pkg::TCS_ADDR: s_d.tcs = i_sfr.wdata;
        dtc_pkg::TMODE_ADDR: s_d.tmode = i_sfr.wdata;
        dtc_pkg::T0L_ADDR: s_d.t0_low = i_sfr.wdata;
        dtc_pkg::T1L_ADDR: s_d.t1_low = i_sfr.wdata;
        dtc_pkg::T0H_ADDR: s_d.t0_high = i_sfr.wdata;
        dtc_pkg::T1H_ADDR: s_d.t1_high = i_sfr.wdata;
        // unmapped writes change nothing
        default: ;
      endcase
    end
    if (i_ack.t0_ack) begin
      s_d.tcs[dtc_pkg::TCS_TF0] = 1'b0;
    end
    if (i_ack.t1_ack) begin
      s_d.tcs[dtc_pkg::TCS_TF1] = 1'b0;
    end
    if (i_ack.x0_ack) begin
      s_d.tcs[dtc_pkg::TCS_IE0] = 1'b0;
    end
    if (i_ack.x1_ack) begin
      s_d.tcs[dtc_pkg::TCS_IE1] = 1'b0;
    end

    // counting works on held values, run never clears them
    if (en0 && tick0) begin
      unique case (m0)
        dtc_pkg::DTC_MODE_13: begin
          ovf0 = (s_q.t0_high == dtc_pkg::BYTE_ONES) && (s_q.t0_low[4:0] == dtc_pkg::M0_LOW_ONES);
          if (s_q.t0_low[4:0] == dtc_pkg::M0_LOW_ONES) begin
            s_d.t0_high = s_q.t0_high + 8'h01;
          end
          s_d.t0_low = {s_q.t0_low[7:5], s_q.t0_low[4:0] + 5'h01};
        end
        dtc_pkg::DTC_MODE_16: begin
          c16 = {s_q.t0_high, s_q.t0_low} + 16'h0001;
          ovf0 = ({s_q.t0_high, s_q.t0_low} == 16'hffff);
          {s_d.t0_high, s_d.t0_low} = c16;
        end
        // low byte counts, reload keeps high byte
        dtc_pkg::DTC_MODE_RELOAD: begin
          ovf0 = (s_q.t0_low == dtc_pkg::BYTE_ONES);
          s_d.t0_low = ovf0 ? s_q.t0_high : s_q.t0_low + 8'h01;
        end
        // split low byte with timer 0 controls
        dtc_pkg::DTC_MODE_SPLIT: begin
          c9 = {1'b0, s_q.t0_low} + 9'h001;
          ovf0 = c9[8];
          s_d.t0_low = c9[7:0];
        end
      endcase
    end
    // split high byte on internal timebase, gated by timer 1 run
    if (split && s_q.tcs[dtc_pkg::TCS_TR1] && int_tick0) begin
      ovf_th0 = (s_q.t0_high == dtc_pkg::BYTE_ONES);
      s_d.t0_high = s_q.t0_high + 8'h01;
    end

    // under split mode timer 1 runs on mode only, stops in mode 3
    if ((split ? (m1 != dtc_pkg::DTC_MODE_SPLIT) : en1) && tick1) begin
      unique case (m1)
        dtc_pkg::DTC_MODE_13: begin
          ovf1 = (s_q.t1_high == dtc_pkg::BYTE_ONES) && (s_q.t1_low[4:0] == dtc_pkg::M0_LOW_ONES);
          if (s_q.t1_low[4:0] == dtc_pkg::M0_LOW_ONES) begin
            s_d.t1_high = s_q.t1_high + 8'h01;
          end
          s_d.t1_low = {s_q.t1_low[7:5], s_q.t1_low[4:0] + 5'h01};
        end
        dtc_pkg::DTC_MODE_16: begin
          ovf1 = ({s_q.t1_high, s_q.t1_low} == 16'hffff);
          {s_d.t1_high, s_d.t1_low} = {s_q.t1_high, s_q.t1_low} + 16'h0001;
        end
        dtc_pkg::DTC_MODE_RELOAD: begin
          ovf1 = (s_q.t1_low == dtc_pkg::BYTE_ONES);
          s_d.t1_low = ovf1 ? s_q.t1_high : s_q.t1_low + 8'h01;
        end
        // timer 1 holds its count in mode 3
        dtc_pkg::DTC_MODE_SPLIT: ;
      endcase
    end

    // hardware set wins over a same-cycle clear
    if (ovf0) begin
      s_d.tcs[dtc_pkg::TCS_TF0] = 1'b1;
    end
    // split high byte owns the timer 1 flag
    if (split ? ovf_th0 : ovf1) begin
      s_d.tcs[dtc_pkg::TCS_TF1] = 1'b1;
    end
    // timer 1 overflow pulse for baud and converter triggers
    // kept apart from the flag, so split mode still feeds the baud source
    s_d.t1_ovf = ovf1;

    // level or edge detection of the external interrupt inputs
    if (s_q.tcs[dtc_pkg::TCS_IT0]) begin
      if (x0_act_next && !x0_act) begin
        s_d.tcs[dtc_pkg::TCS_IE0] = 1'b1;
      end
    end else begin
      s_d.tcs[dtc_pkg::TCS_IE0] = x0_act;
    end
    if (s_q.tcs[dtc_pkg::TCS_IT1]) begin
      if (x1_act_next && !x1_act) begin
        s_d.tcs[dtc_pkg::TCS_IE1] = 1'b1;
      end
    end else begin
      s_d.tcs[dtc_pkg::TCS_IE1] = x1_act;
    end
    if (wr_tcs) begin
      s_d.tcs[dtc_pkg::TCS_IT0] = i_sfr.wdata[dtc_pkg::TCS_IT0];
      s_d.tcs[dtc_pkg::TCS_IT1] = i_sfr.wdata[dtc_pkg::TCS_IT1];
    end

    // timer interrupt requests follow flags and enables, external requests follow their flags alone
    s_d.t0_irq = s_d.tcs[dtc_pkg::TCS_TF0] && i_timer0_irq_enable;
    s_d.t1_irq = s_d.tcs[dtc_pkg::TCS_TF1] && i_timer1_irq_enable;
    s_d.x0_irq = s_d.tcs[dtc_pkg::TCS_IE0];
    s_d.x1_irq = s_d.tcs[dtc_pkg::TCS_IE1];

    // read data registered one cycle after the read strobe
    if (i_sfr.rd) begin
      unique case (i_sfr.addr)
        dtc_pkg::TCS_ADDR: s_d.rdata = s_q.tcs;
        dtc_pkg::TMODE_ADDR: s_d.rdata = s_q.tmode;
        dtc_pkg::T0L_ADDR: s_d.rdata = s_q.t0_low;
        dtc_pkg::T1L_ADDR: s_d.rdata = s_q.t1_low;
        dtc_pkg::T0H_ADDR: s_d.rdata = s_q.t0_high;
        dtc_pkg::T1H_ADDR: s_d.rdata = s_q.t1_high;
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      s_q <= '0;
      s_q.tcs <= dtc_pkg::TCS_RESET;
      s_q.tmode <= dtc_pkg::TMODE_RESET;
      s_q.t0_low <= dtc_pkg::COUNT_RESET;
      s_q.t0_high <= dtc_pkg::COUNT_RESET;
      s_q.t1_low <= dtc_pkg::COUNT_RESET;
      s_q.t1_high <= dtc_pkg::COUNT_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // outputs, each a field of the state register
  // ------------------------------------------------------------
  assign o_sfr_rdata = s_q.rdata;
  assign o_timer0_irq = s_q.t0_irq;
  assign o_timer1_irq = s_q.t1_irq;
  assign o_ext_irq0_req = s_q.x0_irq;
  assign o_ext_irq1_req = s_q.x1_irq;
  assign o_timer1_overflow = s_q.t1_ovf;

endmodule

`default_nettype wire

// ### bench/dtc_checker.sv
// assertion checker for the dual timer/counter block
`timescale 1ns/1ps
`default_nettype none
module dtc_checker (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire dtc_pkg::dtc_sfr_req_t i_sfr,
  input wire dtc_pkg::dtc_ack_t i_ack,
  input wire logic i_timer0_irq_enable,
  input wire logic i_timer1_irq_enable,
  input wire logic [7:0] o_sfr_rdata,
  input wire logic o_timer0_irq,
  input wire logic o_timer1_irq,
  input wire logic o_timer1_overflow
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic rd_map;
  assign rd_map = i_sfr.addr >= dtc_pkg::TCS_ADDR && i_sfr.addr <= dtc_pkg::T1H_ADDR;
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_rdata_hold: assert property (!i_sfr.rd |=> $stable(o_sfr_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (i_sfr.rd && !rd_map |=> o_sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_mode_readback: assert property (
    i_sfr.wr && i_sfr.addr == 8'h89 ##1 !i_sfr.wr ##1 i_sfr.rd && !i_sfr.wr && i_sfr.addr == 8'h89
    |=> o_sfr_rdata == $past(i_sfr.wdata, 3)) else $error("mode register lost its write");
  a_run_readback: assert property (
    i_sfr.wr && i_sfr.addr == 8'h88 ##1 !i_sfr.wr ##1 i_sfr.rd && !i_sfr.wr && i_sfr.addr == 8'h88
    |=> o_sfr_rdata[6] == $past(i_sfr.wdata[6], 3) && o_sfr_rdata[4] == $past(i_sfr.wdata[4], 3))
    else $error("run bits lost their write");
  a_t0_irq_gated: assert property (!i_timer0_irq_enable |=> !o_timer0_irq)
    else $error("timer0 request while disabled");
  a_t1_irq_gated: assert property (!i_timer1_irq_enable |=> !o_timer1_irq)
    else $error("timer1 request while disabled");
  // a flag only drops through a write or a vectoring acknowledge
  a_t0_irq_drop: assert property ($fell(o_timer0_irq) |->
    !$past(i_timer0_irq_enable) || $past(i_sfr.wr && i_sfr.addr == dtc_pkg::TCS_ADDR) ||
    $past(i_ack.t0_ack))
    else $error("timer0 request dropped without cause");
  a_t1_irq_drop: assert property ($fell(o_timer1_irq) |->
    !$past(i_timer1_irq_enable) || $past(i_sfr.wr && i_sfr.addr == dtc_pkg::TCS_ADDR) ||
    $past(i_ack.t1_ack))
    else $error("timer1 request dropped without cause");
  cover property (o_timer0_irq ##1 !o_timer0_irq);
  cover property (o_timer1_irq);
  cover property (i_sfr.rd && !rd_map);
  cover property (o_timer1_overflow);
endmodule
bind dtc_top dtc_checker i_dtc_checker (.i_clk, .i_resetn, .i_sfr, .i_ack, .i_timer0_irq_enable,
  .i_timer1_irq_enable, .o_sfr_rdata, .o_timer0_irq, .o_timer1_irq, .o_timer1_overflow);
`default_nettype wire

// ### bench/test_dtc_top.sv
// self-checking bench for the dual timer/counter block
`timescale 1ns/1ps
`default_nettype none
module test_dtc_top;
  logic clk, rstn, en0, en1, pol0, tick, pin0;
  logic [1:0] xin;
  dtc_pkg::dtc_sfr_req_t sfr;
  dtc_pkg::dtc_ack_t ack;
  logic [7:0] rdata;
  logic irq0, irq1, x0, x1, t1ovf;
  int fail_count, compares, cycles;
  dtc_top i_dtc_top (.i_clk(clk), .i_resetn(rstn), .i_sfr(sfr), .i_ack(ack),
    .i_timer0_irq_enable(en0), .i_timer1_irq_enable(en1), .i_ext_irq0_polarity(pol0),
    .i_ext_irq1_polarity(1'b1), .i_timer0_sysclk_select(1'b0), .i_timer1_sysclk_select(1'b0),
    .i_prescale_tick(tick), .i_timer0_count_pin(pin0), .i_timer1_count_pin(1'b1),
    .i_ext_irq0_input(xin[0]), .i_ext_irq1_input(xin[1]), .o_sfr_rdata(rdata),
    .o_timer0_irq(irq0), .o_timer1_irq(irq1), .o_ext_irq0_req(x0), .o_ext_irq1_req(x1),
    .o_timer1_overflow(t1ovf));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic conclude();
    if (fail_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // a hang costs one mismatch and ends the run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // idle cycle after each write keeps strobes from being reassigned in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr.wr = 1'b1;
    sfr.addr = a;
    sfr.wdata = d;
    @(negedge clk);
    sfr.wr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr.rd = 1'b1;
    sfr.addr = a;
    @(negedge clk);
    sfr.rd = 1'b0;
    chk(rdata, exp);
    @(negedge clk);
  endtask
  // ticks stand for the prescaled clock, so counts are exact
  task automatic pulse(ref logic s, input int n, input int w);
    repeat (n) begin
      s = ~s;
      repeat (w) @(negedge clk);
      s = ~s;
      repeat (w) @(negedge clk);
    end
  endtask
  initial begin
    rstn = 1'b0;
    sfr = '0;
    ack = '0;
    en0 = 1'b1;
    en1 = 1'b0;
    pol0 = 1'b1;
    tick = 1'b0;
    pin0 = 1'b1;
    xin = 2'b00;
    fail_count = 0;
    compares = 0;
    cycles = 0;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    for (int a = 8'h88; a <= 8'h8d; a++) rd(8'(a), 8'h00);
    rd(8'h90, 8'h00);
    wr(8'h89, 8'h01);
    wr(8'h8a, 8'hfe);
    wr(8'h8c, 8'h12);
    wr(8'h88, 8'h10);
    pulse(tick, 3, 1);
    rd(8'h8a, 8'h01);
    rd(8'h8c, 8'h13);
    wr(8'h8a, 8'hff);
    wr(8'h8c, 8'hff);
    pulse(tick, 1, 1);
    rd(8'h88, 8'h30);
    chk({7'h00, irq0}, 8'h01);
    ack.t0_ack = 1'b1;
    @(negedge clk);
    ack.t0_ack = 1'b0;
    repeat (2) @(negedge clk);
    chk({7'h00, irq0}, 8'h00);
    rd(8'h88, 8'h10);
    wr(8'h89, 8'h02);
    wr(8'h8a, 8'hfe);
    wr(8'h8c, 8'h80);
    pulse(tick, 4, 1);
    rd(8'h8a, 8'h82);
    rd(8'h8c, 8'h80);
    rd(8'h88, 8'h30);
    pulse(tick, 126, 1);
    rd(8'h8a, 8'h80);
    pol0 = 1'b0;
    xin[0] = 1'b1;
    wr(8'h89, 8'h09);
    wr(8'h8a, 8'h00);
    pulse(tick, 2, 1);
    rd(8'h8a, 8'h00);
    xin[0] = 1'b0;
    repeat (5) @(negedge clk);
    pulse(tick, 2, 1);
    rd(8'h8a, 8'h02);
    wr(8'h88, 8'h00);
    pulse(tick, 2, 1);
    rd(8'h8a, 8'h02);
    pol0 = 1'b1;
    wr(8'h88, 8'h10);
    wr(8'h89, 8'h05);
    pulse(pin0, 3, 5);
    pulse(tick, 2, 1);
    rd(8'h8a, 8'h05);
    wr(8'h89, 8'h33);
    rd(8'h89, 8'h33);
    wr(8'h8a, 8'hff);
    wr(8'h8c, 8'hff);
    wr(8'h8b, 8'h00);
    wr(8'h88, 8'h50);
    pulse(tick, 1, 1);
    rd(8'h88, 8'hf0);
    rd(8'h8b, 8'h00);
    chk({7'h00, irq1}, 8'h00);
    en1 = 1'b1;
    repeat (2) @(negedge clk);
    chk({7'h00, irq1}, 8'h01);
    wr(8'h89, 8'h13);
    wr(8'h88, 8'h50);
    pulse(tick, 2, 1);
    rd(8'h8b, 8'h02);
    rd(8'h8c, 8'h02);
    rd(8'h88, 8'h50);
    wr(8'h88, 8'h10);
    rd(8'h88, 8'h10);
    pulse(tick, 1, 1);
    rd(8'h8c, 8'h02);
    wr(8'h8b, 8'hff);
    wr(8'h8d, 8'hff);
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    chk({7'h00, t1ovf}, 8'h01);
    @(negedge clk);
    chk({7'h00, t1ovf}, 8'h00);
    rd(8'h88, 8'h10);
    rd(8'h8b, 8'h00);
    for (int k = 0; k < 2; k++) begin
      wr(8'h88, k ? 8'h04 : 8'h01);
      chk({7'h00, k ? x1 : x0}, 8'h00);
      xin[k] = 1'b1;
      repeat (6) @(negedge clk);
      chk({7'h00, k ? x1 : x0}, 8'h01);
      wr(8'h88, k ? 8'h04 : 8'h01);
      chk({7'h00, k ? x1 : x0}, 8'h00);
      wr(8'h88, 8'h00);
      repeat (2) @(negedge clk);
      chk({7'h00, k ? x1 : x0}, 8'h01);
      xin[k] = 1'b0;
    end
    conclude();
  end
endmodule
`default_nettype wire
